// ### rsq_defs.vh
`ifndef RSQ_DEFS_VH
`define RSQ_DEFS_VH
`define RSQ_CLK_KHZ 20000
`define RSQ_TLOW_MS 35
`define RSQ_TIDLE_MS 50
`define RSQ_TSEXT_MS 25
`define RSQ_ADDR 7'h5a
`define RSQ_NRAIL 8'h0a
`define RSQ_CMD_PAGE 8'h00
`define RSQ_CMD_OPER 8'h01
`define RSQ_CMD_CLEAR 8'h03
`define RSQ_CMD_STORE 8'h15
`define RSQ_CMD_LIMIT 5'h08
`define RSQ_CMD_STATUS 8'h7e
`define RSQ_CMD_VOUT 8'h8b
`define RSQ_CMD_RCFG 8'hd0
`define RSQ_CMD_SLVLO 8'hd1
`define RSQ_CMD_SLVHI 8'hd2
`define RSQ_CMD_TONMAX 8'hd3
`define RSQ_CMD_GMASK 8'hd4
`define RSQ_CMD_GCFG 8'hd5
`define RSQ_CMD_PSLO 8'hd6
`define RSQ_CMD_PSHI 8'hd7
`define RSQ_CMD_PSEN 8'hd8
`define RSQ_OPER_ON 7
`define RSQ_S_UVF 0
`define RSQ_S_UVW 1
`define RSQ_S_OVW 2
`define RSQ_S_OVF 3
`define RSQ_S_PGON 4
`define RSQ_S_PGOFF 5
`define RSQ_S_MLO 6
`define RSQ_S_MHI 7
`define RSQ_C_MON 0
`define RSQ_C_EN 1
`define RSQ_C_MAR 2
`define RSQ_RESP_LSB 3
`define RSQ_MARG_LSB 5
`define RSQ_RESP_RESTART 2'h0
`define RSQ_RESP_IMM 2'h1
`define RSQ_RESP_SEQ 2'h2
`define RSQ_MARG_OFF 2'h0
`define RSQ_MARG_LO 2'h1
`define RSQ_MARG_HI 2'h2
`define RSQ_G_PG 0
`define RSQ_G_FLT 1
`define RSQ_G_WRN 2
`define RSQ_G_PREV 3
`define RSQ_G_INV 4
`define RSQ_G_SM 5
`endif

// ### rsq_supervisor.v
`timescale 1ns/100ps
`include "rsq_defs.vh"
// What this block does
// - abort bus transfer when clock stays low over 35 ms
// - reset transaction after 50 ms bus idle high, unless disabled
// - total clock stretch from each start or repeated start stays within 25 ms
// - slave works from 10 kHz to 400 kHz; host uses 100 or 400
// - standard-style command set, own codes for extra features
// - follows the serial bus protocol and drives an alert line
// - host is master; device only answers as slave
// - orders power-on and power-off of ten rails
// - eight general inputs build ten Boolean logic outputs
// - each logic output has an optional toggle state machine
// - three inputs pick one of eight rail on/off states
// - rail has monitor, enable, margin; at least one required
// - regulated rails checked against two low and two high limits
// - fault triggers restart, immediate, sequenced or group response
// - config held in registers, copied to flash on request
// - each fault logged with a time stamp
// - per-rail status register readable by host
// - margining drives rails to low/high target or trims
// - fault on a master rail switches off its slave rails
// - power good on above on-limit, off below off-limit
// - max turn-on time in ms steps, zero means no limit
module rsq_supervisor #(
  parameter [20:0] LOW_TO = `RSQ_TLOW_MS * `RSQ_CLK_KHZ,
  parameter [20:0] IDLE_TO = `RSQ_TIDLE_MS * `RSQ_CLK_KHZ,
  parameter [20:0] SEXT_MAX = `RSQ_TSEXT_MS * `RSQ_CLK_KHZ,
  parameter [14:0] MS_CYC = `RSQ_CLK_KHZ
) (
  input wire core_clk,
  input wire resetn,
  input wire clkEn,
  input wire serialClockPinIn,
  output reg serialClockPinOut_q,
  output reg serialClockPinOe_q,
  input wire serialDataPinIn,
  output reg serialDataPinOut_q,
  output reg serialDataPinOe_q,
  output reg alertPinOut_q,
  output reg alertPinOe_q,
  input wire busTimeoutDisableBit,
  input wire nvmBusy,
  input wire [79:0] railVolt,
  input wire [7:0] generalInput,
  output reg [9:0] railEnable_q,
  output reg [9:0] marginUp_q,
  output reg [9:0] marginDn_q,
  output reg [9:0] logicOutput_q,
  output reg nvmStore_q,
  output reg faultLogValid_q,
  output reg [3:0] faultLogRail_q,
  output reg [4:0] faultLogKind_q,
  output reg [23:0] faultLogTime_q
);
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RX = 5'h02;
  localparam [4:0] S_ACK = 5'h04;
  localparam [4:0] S_TX = 5'h08;
  localparam [4:0] S_RACK = 5'h10;
  reg [1:0] sclSy, sdaSy;
  reg sclP, sdaP;
  reg [7:0] giA, giS;
  reg [20:0] lowCnt, idleCnt, sextCnt;
  reg [4:0] st;
  reg [3:0] bitCnt, page;
  reg [1:0] byteIdx;
  reg [7:0] sh, cmd;
  reg rw, ackSeen, operOn, psEn, clrQ, seqDownQ;
  reg [7:0] thr [0:79];
  reg [7:0] rcfg [0:9];
  reg [9:0] slv [0:9];
  reg [7:0] tonMax [0:9];
  reg [7:0] gMask [0:9];
  reg [7:0] gCfg [0:9];
  reg [9:0] pState [0:7];
  reg [14:0] msCnt;
  reg [23:0] stamp;
  reg [9:0] pend;
  wire [79:0] statV;
  wire [9:0] pgV, fEvV, grpV, seqV, newV, cfgdV, fltV, wrnV, enD, upD, dnD, loD;
  wire [10:0] pgChain = {pgV, 1'b1};
  wire [10:0] enChain = {1'b0, railEnable_q};
  wire scl = sclSy[1];
  wire sda = sdaSy[1];
  wire busStart = scl & sclP & sdaP & !sda;
  wire busStop = scl & sclP & !sdaP & sda;
  wire sclRise = scl & !sclP;
  wire sclFall = !scl & sclP;
  wire lowTo = lowCnt == LOW_TO;
  wire idleTo = idleCnt == IDLE_TO;
  wire busAbort = lowTo | idleTo;
  wire msTick = msCnt == MS_CYC - 15'h0001;
  wire [2:0] gpSel = giS[2:0];
  wire allPg = &(pgV | ~cfgdV);
  wire [7:0] rdByte = (cmd == `RSQ_CMD_STATUS) ? statV[{page, 3'h0}+:8] :
    (cmd == `RSQ_CMD_VOUT) ? railVolt[{page, 3'h0}+:8] : 8'h00;
  integer k;
  integer j;

  // pins are only read after the second flop; 20 MHz covers 10..400 kHz
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclSy <= 2'h3;
      sdaSy <= 2'h3;
      sclP <= 1'b1;
      sdaP <= 1'b1;
      giA <= 8'h00;
      giS <= 8'h00;
      lowCnt <= 21'h00_0000;
      idleCnt <= 21'h00_0000;
      sextCnt <= 21'h00_0000;
      serialClockPinOe_q <= 1'b0;
      serialClockPinOut_q <= 1'b0;
      serialDataPinOut_q <= 1'b0;
      alertPinOut_q <= 1'b0;
      msCnt <= 15'h0000;
      stamp <= 24'h00_0000;
    end
    else if (clkEn)
    begin
      sclSy <= {sclSy[0], serialClockPinIn};
      sdaSy <= {sdaSy[0], serialDataPinIn};
      sclP <= scl;
      sdaP <= sda;
      giA <= generalInput;
      giS <= giA;
      lowCnt <= scl ? 21'h00_0000 : (lowTo ? lowCnt : lowCnt + 21'h00_0001);
      if (scl & sda & !busTimeoutDisableBit & (st != S_IDLE) & !idleTo)
        idleCnt <= idleCnt + 21'h00_0001;
      else if (!(scl & sda) | (st == S_IDLE))
        idleCnt <= 21'h00_0000;
      if (busStart)
        sextCnt <= 21'h00_0000;
      else if (serialClockPinOe_q)
        sextCnt <= sextCnt + 21'h00_0001;
      // only pull clock when already low, so no false edge is made
      // compare one short: the output flop adds a cycle of pull
      serialClockPinOe_q <= (st != S_IDLE) & nvmBusy & !busAbort &
        (sextCnt < SEXT_MAX - 21'h00_0001) & (!scl | serialClockPinOe_q);
      msCnt <= msTick ? 15'h0000 : msCnt + 15'h0001;
      if (msTick)
        stamp <= stamp + 24'h00_0001;
    end
  end

  // slave engine; device never originates a transfer
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= S_IDLE;
      bitCnt <= 4'h0;
      byteIdx <= 2'h0;
      page <= 4'h0;
      sh <= 8'h00;
      cmd <= 8'h00;
      rw <= 1'b0;
      ackSeen <= 1'b0;
      operOn <= 1'b0;
      psEn <= 1'b0;
      clrQ <= 1'b0;
      nvmStore_q <= 1'b0;
      serialDataPinOe_q <= 1'b0;
      for (k = 0; k < 80; k = k + 1)
        thr[k] <= 8'h00;
      for (k = 0; k < 10; k = k + 1)
      begin
        rcfg[k] <= 8'h00;
        slv[k] <= 10'h000;
        tonMax[k] <= 8'h00;
        gMask[k] <= 8'h00;
        gCfg[k] <= 8'h00;
      end
      for (k = 0; k < 8; k = k + 1)
        pState[k] <= 10'h000;
    end
    else if (clkEn)
    begin
      clrQ <= 1'b0;
      nvmStore_q <= 1'b0;
      if (busAbort)
      begin
        st <= S_IDLE;
        serialDataPinOe_q <= 1'b0;
      end
      else if (busStart)
      begin
        st <= S_RX;
        bitCnt <= 4'h0;
        byteIdx <= 2'h0;
        serialDataPinOe_q <= 1'b0;
      end
      else if (busStop)
      begin
        st <= S_IDLE;
        serialDataPinOe_q <= 1'b0;
      end
      else
        case (st)
          S_RX:
            if (sclRise)
            begin
              sh <= {sh[6:0], sda};
              bitCnt <= bitCnt + 4'h1;
            end
            else if (sclFall && bitCnt == 4'h8)
            begin
              bitCnt <= 4'h0;
              if (byteIdx != 2'h3)
                byteIdx <= byteIdx + 2'h1;
              if (byteIdx == 2'h0 && sh[7:1] != `RSQ_ADDR)
                st <= S_IDLE;
              else
              begin
                st <= S_ACK;
                serialDataPinOe_q <= 1'b1;
              end
              if (byteIdx == 2'h0)
                rw <= sh[0];
              else if (byteIdx == 2'h1)
                cmd <= sh;
              else if (cmd == `RSQ_CMD_PAGE)
              begin
                if (sh < `RSQ_NRAIL)
                  page <= sh[3:0];
              end
              else if (cmd == `RSQ_CMD_OPER)
                operOn <= sh[`RSQ_OPER_ON];
              else if (cmd == `RSQ_CMD_CLEAR)
                clrQ <= 1'b1;
              else if (cmd == `RSQ_CMD_STORE)
                nvmStore_q <= 1'b1;
              else if (cmd[7:3] == `RSQ_CMD_LIMIT)
                thr[{page, cmd[2:0]}] <= sh;
              else if (cmd == `RSQ_CMD_RCFG)
                rcfg[page] <= sh;
              else if (cmd == `RSQ_CMD_SLVLO)
                slv[page][7:0] <= sh;
              else if (cmd == `RSQ_CMD_SLVHI)
                slv[page][9:8] <= sh[1:0];
              else if (cmd == `RSQ_CMD_TONMAX)
                tonMax[page] <= sh;
              else if (cmd == `RSQ_CMD_GMASK)
                gMask[page] <= sh;
              else if (cmd == `RSQ_CMD_GCFG)
                gCfg[page] <= sh;
              else if (cmd == `RSQ_CMD_PSLO)
                pState[page[2:0]][7:0] <= sh;
              else if (cmd == `RSQ_CMD_PSHI)
                pState[page[2:0]][9:8] <= sh[1:0];
              else if (cmd == `RSQ_CMD_PSEN)
                psEn <= sh[0];
            end
          S_ACK:
            if (sclFall)
            begin
              bitCnt <= 4'h0;
              sh <= rdByte;
              serialDataPinOe_q <= rw & !rdByte[7];
              st <= rw ? S_TX : S_RX;
            end
          S_TX:
            if (sclFall)
            begin
              if (bitCnt == 4'h7)
              begin
                serialDataPinOe_q <= 1'b0;
                st <= S_RACK;
              end
              else
              begin
                sh <= {sh[6:0], 1'b0};
                serialDataPinOe_q <= !sh[6];
                bitCnt <= bitCnt + 4'h1;
              end
            end
          S_RACK:
            if (sclRise)
              ackSeen <= !sda;
            else if (sclFall)
            begin
              bitCnt <= 4'h0;
              sh <= rdByte;
              serialDataPinOe_q <= ackSeen & !rdByte[7];
              st <= ackSeen ? S_TX : S_IDLE;
            end
          default:
            st <= S_IDLE;
        endcase
    end
  end

  genvar i, m;
  generate
    for (i = 0; i < 10; i = i + 1)
    begin : gRail
      wire [7:0] v = railVolt[i*8+:8];
      wire [7:0] c = rcfg[i];
      wire [1:0] resp = c[`RSQ_RESP_LSB+:2];
      wire [1:0] mm = c[`RSQ_MARG_LSB+:2];
      wire [7:0] mLo = thr[i*8+`RSQ_S_MLO];
      wire [7:0] mHi = thr[i*8+`RSQ_S_MHI];
      wire [8:0] mSum = {1'b0, mLo} + {1'b0, mHi};
      wire [7:0] tgt = (mm == `RSQ_MARG_LO) ? mLo : (mm == `RSQ_MARG_HI) ? mHi : mSum[8:1];
      wire [9:0] slvCol;
      reg pg_q, fPrev_q, kill_q, bnc_q;
      reg [4:0] stat_q;
      reg [7:0] ton_q;
      for (m = 0; m < 10; m = m + 1)
      begin : gCol
        assign slvCol[m] = slv[m][i];
      end
      wire en = railEnable_q[i];
      wire cmdOn = psEn ? pState[gpSel][i] : operOn;
      wire want = cfgdV[i] & cmdOn & !seqDownQ & !kill_q & !bnc_q;
      wire uvF = pg_q & (v < thr[i*8+`RSQ_S_UVF]);
      wire uvW = pg_q & (v < thr[i*8+`RSQ_S_UVW]);
      wire ovW = pg_q & (v > thr[i*8+`RSQ_S_OVW]);
      wire ovF = pg_q & (v > thr[i*8+`RSQ_S_OVF]);
      wire tonF = en & !pg_q & (tonMax[i] != 8'h00) & (ton_q >= tonMax[i]);
      wire [4:0] cur = {tonF, ovF, ovW, uvW, uvF};
      wire fNow = uvF | ovF | tonF;
      wire hitK = |(fEvV & ~grpV & slvCol);
      wire hitB = |(fEvV & grpV & slvCol);
      assign cfgdV[i] = |c[2:0];
      assign pgV[i] = pg_q;
      assign fEvV[i] = fNow & !fPrev_q;
      assign grpV[i] = (resp == `RSQ_RESP_RESTART) | (resp == 2'h3);
      assign seqV[i] = fEvV[i] & (resp == `RSQ_RESP_SEQ);
      assign newV[i] = |(cur & ~stat_q);
      assign fltV[i] = stat_q[`RSQ_S_UVF] | stat_q[`RSQ_S_OVF] | stat_q[4];
      assign wrnV[i] = stat_q[`RSQ_S_UVW] | stat_q[`RSQ_S_OVW];
      assign statV[i*8+:8] = {3'h0, stat_q};
      // on in index order after the lower rail is good, off in reverse
      assign enD[i] = want ? (en | pgChain[i]) :
        (en & enChain[i+1] & !kill_q & !bnc_q);
      assign upD[i] = c[`RSQ_C_MAR] & (mm != `RSQ_MARG_OFF) & en & (v < tgt);
      assign dnD[i] = c[`RSQ_C_MAR] & (mm != `RSQ_MARG_OFF) & en & (v > tgt);
      always @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          pg_q <= 1'b0;
          fPrev_q <= 1'b0;
          kill_q <= 1'b0;
          bnc_q <= 1'b0;
          stat_q <= 5'h00;
          ton_q <= 8'h00;
        end
        else if (clkEn)
        begin
          // unmonitored rail counts as good once enabled
          pg_q <= c[`RSQ_C_MON] ? (v >= (pg_q ? thr[i*8+`RSQ_S_PGOFF] :
            thr[i*8+`RSQ_S_PGON])) : en;
          fPrev_q <= fNow;
          stat_q <= (clrQ ? 5'h00 : stat_q) | cur;
          if (!en | pg_q)
            ton_q <= 8'h00;
          else if (msTick && ton_q != 8'hff)
            ton_q <= ton_q + 8'h01;
          kill_q <= (kill_q & !clrQ) | hitK |
            (fEvV[i] & (resp == `RSQ_RESP_IMM));
          // a bounce holds the rail off to the next ms, then re-sequences
          bnc_q <= (bnc_q & !msTick) | hitB | (fEvV[i] & grpV[i]);
        end
      end
    end
    for (i = 0; i < 10; i = i + 1)
    begin : gLogic
      wire [7:0] gm = gMask[i];
      wire [7:0] gc = gCfg[i];
      reg cp_q;
      wire term = (&(~gm | giS)) & (!gc[`RSQ_G_PG] | allPg) &
        (!gc[`RSQ_G_FLT] | (|fltV)) & (!gc[`RSQ_G_WRN] | (|wrnV)) &
        (!gc[`RSQ_G_PREV] | logicOutput_q[(i+9)%10]);
      wire comb = term ^ gc[`RSQ_G_INV];
      assign loD[i] = gc[`RSQ_G_SM] ? (logicOutput_q[i] ^ (comb & !cp_q)) : comb;
      always @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
          cp_q <= 1'b0;
        else if (clkEn)
          cp_q <= comb;
      end
    end
  endgenerate

  reg [3:0] pick;
  reg pickV;
  always @*
  begin
    pick = 4'h0;
    pickV = 1'b0;
    for (j = 9; j >= 0; j = j - 1)
      if (pend[j])
      begin
        pick = j[3:0];
        pickV = 1'b1;
      end
  end

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      railEnable_q <= 10'h000;
      marginUp_q <= 10'h000;
      marginDn_q <= 10'h000;
      logicOutput_q <= 10'h000;
      alertPinOe_q <= 1'b0;
      seqDownQ <= 1'b0;
      pend <= 10'h000;
      faultLogValid_q <= 1'b0;
      faultLogRail_q <= 4'h0;
      faultLogKind_q <= 5'h00;
      faultLogTime_q <= 24'h00_0000;
    end
    else if (clkEn)
    begin
      railEnable_q <= enD;
      marginUp_q <= upD;
      marginDn_q <= dnD;
      logicOutput_q <= loD;
      alertPinOe_q <= (alertPinOe_q & !clrQ) | (|newV);
      seqDownQ <= (seqDownQ & !clrQ) | (|seqV);
      // one log entry a cycle, lowest rail first; set beats the take
      pend <= (pend & ~(pickV ? (10'h001 << pick) : 10'h000)) | fEvV;
      faultLogValid_q <= pickV;
      if (pickV)
      begin
        faultLogRail_q <= pick;
        faultLogKind_q <= statV[{pick, 3'h0}+:5];
        faultLogTime_q <= stamp;
      end
    end
  end
endmodule // rsq_supervisor

// ### rsq_monitor.sv
`timescale 1ns/100ps
module rsq_monitor #(
  parameter [20:0] LOW_TO = 21'h00_00c8,
  parameter [20:0] SEXT_MAX = 21'h00_0096
) (
  input wire core_clk,
  input wire resetn,
  input wire clkEn,
  input wire serialClockPinIn,
  input wire serialClockPinOut_q,
  input wire serialClockPinOe_q,
  input wire serialDataPinOut_q,
  input wire serialDataPinOe_q,
  input wire alertPinOut_q,
  input wire nvmStore_q,
  input wire faultLogValid_q,
  input wire [3:0] faultLogRail_q,
  input wire [4:0] faultLogKind_q,
  input wire [9:0] railEnable_q
);
  reg [20:0] lowCnt_q;
  reg [20:0] extCnt_q;
  // consecutive stretch only: a lower bound of the per-message total
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lowCnt_q <= 21'h00_0000;
      extCnt_q <= 21'h00_0000;
    end
    else if (clkEn)
    begin
      lowCnt_q <= serialClockPinIn ? 21'h00_0000 : lowCnt_q + 21'h00_0001;
      extCnt_q <= serialClockPinOe_q ? extCnt_q + 21'h00_0001 : 21'h00_0000;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_logPulse;
    faultLogValid_q ##1 !faultLogValid_q;
  endsequence
  sequence s_quietBus;
    !serialDataPinOe_q && !serialClockPinOe_q;
  endsequence
  a_open_drain: assert property (!(serialClockPinOut_q | serialDataPinOut_q | alertPinOut_q))
    else $error("open drain pin driven high");
  a_low_abort: assert property ((lowCnt_q > LOW_TO + 21'h00_0006) |-> s_quietBus)
    else $error("bus held after clock low timeout");
  a_stretch_cap: assert property (extCnt_q <= SEXT_MAX)
    else $error("clock stretch too long");
  a_data_change: assert property ($changed(serialDataPinOe_q) |-> !serialClockPinIn)
    else $error("data changed while clock high");
  a_store_pulse: assert property (nvmStore_q |=> !nvmStore_q)
    else $error("store request longer than one cycle");
  a_log_pulse: assert property ($rose(faultLogValid_q) |-> s_logPulse)
    else $error("log strobe longer than one cycle");
  a_log_fields: assert property (faultLogValid_q |-> faultLogKind_q != 5'h00 && faultLogRail_q < 4'ha)
    else $error("log entry malformed");
  a_rail_order: assert property (((railEnable_q & ~$past(railEnable_q)) & ~{$past(railEnable_q[8:0]), 1'b1}) == 10'h000)
    else $error("rail enabled before its predecessor");
endmodule // rsq_monitor
bind rsq_supervisor rsq_monitor #(.LOW_TO(LOW_TO), .SEXT_MAX(SEXT_MAX)) i_mon (.core_clk(core_clk),
  .resetn(resetn), .clkEn(clkEn), .serialClockPinIn(serialClockPinIn),
  .serialClockPinOut_q(serialClockPinOut_q), .serialClockPinOe_q(serialClockPinOe_q),
  .serialDataPinOut_q(serialDataPinOut_q), .serialDataPinOe_q(serialDataPinOe_q),
  .alertPinOut_q(alertPinOut_q), .nvmStore_q(nvmStore_q), .faultLogValid_q(faultLogValid_q),
  .faultLogRail_q(faultLogRail_q), .faultLogKind_q(faultLogKind_q), .railEnable_q(railEnable_q));

// ### rsq_host.sv
`timescale 1ns/100ps
module rsq_host (
  output logic clkOe,
  output logic datOe,
  input wire logic sclIn,
  input wire logic sdaIn
);
  initial
  begin
    clkOe = 1'b0;
    datOe = 1'b0;
  end
  // low 300 ns, high 100 ns; waits out clock stretching
  task automatic bitx(input logic b, output logic r);
    int n;
    n = 0;
    datOe = !b;
    #150 clkOe = 1'b0;
    while (!sclIn && n < 400)
    begin
      #50 n++;
    end
    #100 r = sdaIn;
    clkOe = 1'b1;
    #150;
  endtask
  task automatic xbyte(input logic [7:0] v, output logic [7:0] rv, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bitx(v[i], rv[i]);
    bitx(1'b1, a);
    ack = !a;
  endtask
  task automatic start();
    datOe = 1'b1;
    #200 clkOe = 1'b1;
    #150;
  endtask
  task automatic rstart();
    datOe = 1'b0;
    #150 clkOe = 1'b0;
    #200 datOe = 1'b1;
    #200 clkOe = 1'b1;
    #150;
  endtask
  task automatic stop();
    datOe = 1'b1;
    #150 clkOe = 1'b0;
    #200 datOe = 1'b0;
    #400;
  endtask
  // both lines released mid-message for t ns
  task automatic relax(input int t);
    datOe = 1'b0;
    #150 clkOe = 1'b0;
    #(t) clkOe = 1'b1;
    #150;
  endtask
endmodule // rsq_host

// ### rsq_supervisor_bench.sv
`timescale 1ns/100ps
`include "rsq_defs.vh"
module rsq_supervisor_bench;
  logic core_clk, resetn, nvmBusy, toDis, clkEn;
  logic [79:0] railVolt;
  logic [7:0] rv, gi;
  logic [23:0] lastTime;
  logic [4:0] lastKind;
  logic [3:0] lastRail;
  logic ack;
  wire sclOe, sdaOe, alertOe, mClkOe, mDatOe, store, logValid, sclO, sdaO, alertO;
  wire sclPin = !(sclOe | mClkOe);
  wire sdaPin = !(sdaOe | mDatOe);
  wire [9:0] railEn, mUp, mDn, logicOut;
  wire [3:0] logRail;
  wire [4:0] logKind;
  wire [23:0] logTime;
  int fail_count = 0, n_compared = 0, cyc = 0, stores = 0, logs = 0, ext = 0;
  rsq_supervisor #(.LOW_TO(21'h00_00c8), .IDLE_TO(21'h00_012c), .SEXT_MAX(21'h00_0096),
    .MS_CYC(15'h0014)) i_dut (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
    .serialClockPinIn(sclPin), .serialClockPinOut_q(sclO), .serialClockPinOe_q(sclOe),
    .serialDataPinIn(sdaPin), .serialDataPinOut_q(sdaO), .serialDataPinOe_q(sdaOe),
    .alertPinOut_q(alertO), .alertPinOe_q(alertOe), .busTimeoutDisableBit(toDis),
    .nvmBusy(nvmBusy), .railVolt(railVolt), .generalInput(gi), .railEnable_q(railEn),
    .marginUp_q(mUp), .marginDn_q(mDn), .logicOutput_q(logicOut), .nvmStore_q(store),
    .faultLogValid_q(logValid), .faultLogRail_q(logRail), .faultLogKind_q(logKind),
    .faultLogTime_q(logTime));
  rsq_host i_host (.clkOe(mClkOe), .datOe(mDatOe), .sclIn(sclPin), .sdaIn(sdaPin));
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (store) stores++;
    if (sclOe) ext++;
    if (logValid)
    begin
      logs++;
      lastRail = logRail;
      lastKind = logKind;
      lastTime = logTime;
    end
    if (cyc == 60000)
    begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // m: 0 plain, 1 clock held low, 2 bus idle high, before the data byte
  // m 2 sends {1, d[6:0]}: the idle high phase is itself a clocked 1 bit
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic e, input int m);
    logic a1, a2, a3;
    @(negedge core_clk);
    i_host.start();
    i_host.xbyte({`RSQ_ADDR, 1'b0}, rv, a1);
    i_host.xbyte(c, rv, a2);
    if (m == 1) #20000;
    if (m == 2)
    begin
      i_host.relax(20000);
      for (int i = 6; i >= 0; i--)
        i_host.bitx(d[i], rv[i]);
      i_host.bitx(1'b1, a3);
      a3 = !a3;
    end
    else
      i_host.xbyte(d, rv, a3);
    i_host.stop();
    chk("ack", a1 & a2 & a3, e);
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    logic a;
    @(negedge core_clk);
    i_host.start();
    i_host.xbyte({`RSQ_ADDR, 1'b0}, d, a);
    i_host.xbyte(c, d, a);
    i_host.rstart();
    i_host.xbyte({`RSQ_ADDR, 1'b1}, d, a);
    i_host.xbyte(8'hff, d, a);
    i_host.stop();
  endtask
  task automatic waitRails(input logic [9:0] e);
    for (int k = 0; k < 400 && railEn !== e; k++)
      @(negedge core_clk);
    chk("railEnable", railEn, e);
  endtask
  task automatic t_rails();
    chk("reset rails", railEn, 10'h000);
    wr(`RSQ_CMD_PAGE, 8'h00, 1, 0);
    wr(`RSQ_CMD_RCFG, 8'h02, 1, 0);
    wr(`RSQ_CMD_OPER, 8'h80, 1, 0);
    wr(`RSQ_CMD_PAGE, 8'h01, 1, 0);
    // limits first: a zero over-voltage fault limit would trip as soon as the rail is good
    wr(8'h40, 8'h30, 1, 0);
    wr(8'h42, 8'hff, 1, 0);
    wr(8'h43, 8'hff, 1, 0);
    wr(8'h44, 8'h40, 1, 0);
    wr(`RSQ_CMD_RCFG, 8'h03, 1, 0);
    wr(`RSQ_CMD_OPER, 8'h80, 1, 0);
    waitRails(10'h003);
  endtask
  task automatic t_read();
    rd(`RSQ_CMD_VOUT, rv);
    chk("voltage", rv, 8'h50);
    rd(`RSQ_CMD_STATUS, rv);
    chk("status", rv, 8'h00);
    chk("open drain", {sclO, sdaO, alertO}, 3'h0);
    @(negedge core_clk);
    i_host.start();
    i_host.xbyte({`RSQ_ADDR ^ 7'h01, 1'b0}, rv, ack);
    i_host.stop();
    chk("foreign ack", ack, 1'b0);
  endtask
  task automatic t_timeouts();
    wr(`RSQ_CMD_OPER, 8'h00, 0, 1);
    waitRails(10'h003);
    wr(`RSQ_CMD_OPER, 8'h00, 0, 2);
    waitRails(10'h003);
    @(posedge core_clk) toDis <= 1'b1;
    wr(`RSQ_CMD_PAGE, 8'h01, 1, 2);
    @(posedge core_clk) toDis <= 1'b0;
  endtask
  task automatic t_store();
    @(posedge core_clk) nvmBusy <= 1'b1;
    ext = 0;
    wr(`RSQ_CMD_STORE, 8'h00, 1, 0);
    chk("stretch seen", ext > 0 && ext <= 150, 1'b1);
    @(posedge core_clk) nvmBusy <= 1'b0;
    chk("store pulses", stores > 0, 1'b1);
  endtask
  task automatic t_fault();
    @(posedge core_clk) railVolt[15:8] <= 8'h20;
    for (int k = 0; k < 400 && alertOe !== 1'b1; k++)
      @(negedge core_clk);
    chk("alert set", alertOe, 1'b1);
    @(posedge core_clk) railVolt[15:8] <= 8'h50;
    repeat (3) @(negedge core_clk);
    chk("log seen", logs > 0, 1'b1);
    chk("log time", lastTime > 0 && lastTime <= cyc / 20, 1'b1);
    chk("log rail", lastRail, 4'h1);
    chk("log kind", lastKind, 5'h01);
    rd(`RSQ_CMD_STATUS, rv);
    chk("status uv", rv, 8'h01);
    wr(`RSQ_CMD_CLEAR, 8'h00, 1, 0);
    repeat (5) @(negedge core_clk);
    chk("alert clear", alertOe, 1'b0);
  endtask
  task automatic t_pins();
    wr(`RSQ_CMD_RCFG, 8'h27, 1, 0);
    chk("margin down", mDn, 10'h002);
    chk("margin up", mUp, 10'h000);
    wr(`RSQ_CMD_PSLO, 8'h01, 1, 0);
    wr(`RSQ_CMD_PAGE, 8'h00, 1, 0);
    wr(`RSQ_CMD_GMASK, 8'h01, 1, 0);
    @(posedge core_clk) gi <= 8'h01;
    wr(`RSQ_CMD_PSEN, 8'h01, 1, 0);
    waitRails(10'h001);
    chk("logic out", logicOut, 10'h3ff);
    @(posedge core_clk) clkEn <= 1'b0;
    gi <= 8'h00;
    repeat (8) @(negedge core_clk);
    chk("frozen logic", logicOut, 10'h3ff);
    chk("frozen rails", railEn, 10'h001);
    @(posedge core_clk) clkEn <= 1'b1;
    waitRails(10'h000);
    chk("logic low", logicOut, 10'h3fe);
    wr(`RSQ_CMD_PSEN, 8'h00, 1, 0);
    waitRails(10'h003);
    wr(`RSQ_CMD_GCFG, 8'h20, 1, 0);
    @(posedge core_clk) gi <= 8'h01;
    repeat (8) @(posedge core_clk);
    gi <= 8'h00;
    repeat (8) @(negedge core_clk);
    chk("toggle out", logicOut, 10'h3ff);
  endtask
  task end_sim();
    $display("comparisons %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    resetn = 1'b0;
    nvmBusy = 1'b0;
    toDis = 1'b0;
    clkEn = 1'b1;
    gi = 8'h00;
    railVolt = 80'h0000_0000_0000_0000_5000;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    #37;
    t_rails();
    t_read();
    t_timeouts();
    t_store();
    t_fault();
    t_pins();
    end_sim();
  end
endmodule // rsq_supervisor_bench
